// File: dv/dio_pin_model.sv
// Purpose: external side of the wide port and function line pins
// Assumes: ext_* carry what outside drivers put on released lines
// Notes:   released lines with no driver sit at the pull-down level
`timescale 1ns/1ps

module dio_pin_model (
  // design side
  input  logic [31:0] wp_out,
  input  logic [31:0] wp_oe,
  input  logic [15:0] fl_out,
  input  logic [15:0] fl_oe,
  // outside drivers, zero where nothing drives
  input  logic [31:0] ext_wp,
  input  logic [15:0] ext_fl,
  // resolved pin levels
  output logic [31:0] wp_in,
  output logic [15:0] fl_in
);
  assign wp_in = (wp_oe & wp_out) | (~wp_oe & ext_wp);
  // outside strobes enter here, the block makes none
  assign fl_in = (fl_oe & fl_out) | (~fl_oe & ext_fl);
endmodule : dio_pin_model

// File: dv/dio_wave_port_monitor.sv
// Purpose: concurrent checks on the waveform port's host and strobe ports
// Assumes: strobe sources 16 and 17 select int_strobe[0] and [1]
// Notes:   sticky flags are checked against their causes, counts against the depth
`timescale 1ns/1ps

module dio_wave_port_monitor #(
  parameter int  DEPTH = 2047,
  localparam int CW    = $clog2(DEPTH + 1)
) (
  // clock and reset
  input logic               clock,
  input logic               reset,
  // strobes
  input logic [7:0]         int_strobe,
  // capture side
  input logic               di_en,
  input logic [4:0]         di_src_sel,
  input dio_pkg::dio_xfer_t di_xfer,
  input logic               di_rd_req,
  input logic               di_rd_ack,
  input logic               di_req,
  input logic [CW-1:0]      di_count,
  input logic               di_overflow,
  input logic               di_ovf_clr,
  // generation side
  input logic               do_en,
  input logic [4:0]         do_src_sel,
  input logic               do_full,
  input logic [CW-1:0]      do_count,
  input logic               do_underrun
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence cap_edge;
    $rose(int_strobe[0]) && di_src_sel == 5'h10 && di_en;
  endsequence
  sequence upd_edge;
    $rose(int_strobe[1]) && do_src_sel == 5'h11 && do_en;
  endsequence

  a_read_ack: assert property (di_rd_req && di_count != 0 |=> di_rd_ack)
    else $error("read not acknowledged");
  a_empty_read: assert property (di_rd_req && di_count == 0 |=> !di_rd_ack)
    else $error("read of empty queue acknowledged");
  a_count_cap: assert property (di_count <= DEPTH && do_count <= DEPTH)
    else $error("queue count beyond depth");
  a_full_flag: assert property (do_full == (do_count == DEPTH))
    else $error("full flag disagrees with count");
  a_overflow_holds: assert property (di_overflow && !di_ovf_clr |=> di_overflow)
    else $error("overflow flag lost");
  a_dma_request: assert property ($past(di_xfer) == dio_pkg::DIO_XF_DMA && !$past(reset)
    |-> di_req == ($past(di_count) != 0))
    else $error("capture request wrong in dma mode");
  a_overflow_set: assert property (cap_edge ##0 (di_count == DEPTH && !di_rd_req) |=> di_overflow)
    else $error("dropped capture not flagged");
  a_underrun_set: assert property (upd_edge ##0 do_count == 0 |=> do_underrun)
    else $error("empty update not flagged");
endmodule : dio_wave_port_monitor

bind dio_wave_port dio_wave_port_monitor #(.DEPTH(DEPTH)) u_mon (
  .clock, .reset, .int_strobe, .di_en, .di_src_sel, .di_xfer, .di_rd_req, .di_rd_ack, .di_req,
  .di_count, .di_overflow, .di_ovf_clr, .do_en, .do_src_sel, .do_full, .do_count, .do_underrun
);

// File: dv/tb_dio_wave_port.sv
// Purpose: directed test of capture, generation and function lines
// Assumes: queue depth shrunk to 8, long filter to 20 cycles
// Notes:   inputs move on rising edges, outputs are read on falling edges
`timescale 1ns/1ps

`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; $display("ERROR %0t: mismatch", $time); end end

module tb_dio_wave_port;
  logic clock = 0;
  logic reset = 1;
  logic [31:0] wp_in, wp_out, wp_oe, wp_dir, wp_static_out, wp_rd, di_rd_data, do_wr_data, ext_wp, d;
  logic [15:0] fl_in, fl_out, fl_oe, fl_static_out, fl_rd, ext_fl;
  dio_pkg::dio_flmode_t [15:0] fl_mode;
  dio_pkg::dio_filt_t [15:0] fl_filt;
  logic [15:0][1:0] fl_tsel;
  logic [7:0] int_strobe;
  logic [1:0] timing_src;
  logic [4:0] di_src_sel, do_src_sel;
  dio_pkg::dio_xfer_t di_xfer, do_xfer;
  logic di_en, di_rd_req, di_rd_ack, di_req, di_overflow, di_ovf_clr;
  logic do_en, do_regen, do_wr_req, do_full, do_req, do_underrun, do_unf_clr;
  logic [3:0] di_count, do_count;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;

  always #20 clock = ~clock;

  dio_wave_port #(.DEPTH(8), .FLT_C2(16'h0014)) u_dut (
    .clock, .reset, .wp_in, .wp_out, .wp_oe, .wp_dir, .wp_static_out, .wp_rd, .fl_in, .fl_out, .fl_oe,
    .fl_mode, .fl_filt, .fl_tsel, .fl_static_out, .fl_rd, .int_strobe, .timing_src, .di_en, .di_src_sel,
    .di_xfer, .di_rd_req, .di_rd_data, .di_rd_ack, .di_req, .di_count, .di_overflow, .di_ovf_clr, .do_en,
    .do_regen, .do_src_sel, .do_xfer, .do_wr_req, .do_wr_data, .do_full, .do_req, .do_count,
    .do_underrun, .do_unf_clr
  );

  dio_pin_model u_pins (.wp_out, .wp_oe, .fl_out, .fl_oe, .ext_wp, .ext_fl, .wp_in, .fl_in);

  task tally_and_finish;
    if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      tally_and_finish;
    end
  end

  task tick(int n);
    repeat (n) @(posedge clock);
  endtask : tick

  // strobe high one cycle, then low one cycle so the next edge is seen
  task pulse(int k);
    @(posedge clock) int_strobe[k] <= 1'h1;
    @(posedge clock) int_strobe[k] <= 1'h0;
    @(posedge clock);
    @(negedge clock);
  endtask : pulse

  task rd(logic ack);
    @(posedge clock) di_rd_req <= 1'h1;
    @(posedge clock) di_rd_req <= 1'h0;
    @(negedge clock);
    `CHK(di_rd_ack, ack)
    d = di_rd_data;
  endtask : rd

  task wr(logic [31:0] v);
    @(posedge clock) do_wr_req <= 1'h1;
    do_wr_data <= v;
  endtask : wr

  initial begin
    {wp_dir, wp_static_out, do_wr_data, ext_wp, fl_static_out, ext_fl, fl_tsel} = '0;
    for (int k = 0; k < 16; k++) begin
      fl_mode[k] = dio_pkg::DIO_FL_SIN;
      fl_filt[k] = dio_pkg::DIO_FLT_OFF;
    end
    {int_strobe, timing_src, di_src_sel, do_src_sel} = '0;
    di_xfer = dio_pkg::DIO_XF_PIO;
    do_xfer = dio_pkg::DIO_XF_PIO;
    {di_en, di_rd_req, di_ovf_clr, do_en, do_regen, do_wr_req, do_unf_clr} = '0;
    tick(5);
    reset <= 1'h0;
    // static directions, per bit
    wp_dir <= 32'hFFFF_0000;
    wp_static_out <= 32'h1234_5678;
    ext_wp <= 32'h0000_9ABC;
    tick(6);
    @(negedge clock);
    `CHK(wp_oe, 32'hFFFF_0000)
    `CHK(wp_rd, 32'h1234_9ABC)
    // capture past the queue depth
    @(posedge clock) wp_dir <= '0;
    di_en <= 1'h1;
    di_src_sel <= 5'h10;
    di_xfer <= dio_pkg::DIO_XF_DMA;
    for (int i = 1; i <= 9; i++) begin
      @(posedge clock) ext_wp <= {8{i[3:0]}};
      tick(3);
      pulse(0);
    end
    `CHK(di_count, 4'h8)
    `CHK(di_overflow, 1'h1)
    `CHK(di_req, 1'h1)
    // drain under the half-full request, threshold 4 for a depth of 8
    @(posedge clock) di_xfer <= dio_pkg::DIO_XF_IRQ;
    for (int i = 1; i <= 8; i++) begin
      rd(1'h1);
      `CHK(d, {8{i[3:0]}})
      `CHK(di_req, (9 - i) >= 4)
    end
    rd(1'h0);
    @(posedge clock) di_ovf_clr <= 1'h1;
    @(posedge clock) di_ovf_clr <= 1'h0;
    @(negedge clock);
    `CHK(di_overflow, 1'h0)
    `CHK(di_req, 1'h0)
    // streaming generation, one write past full, one update past empty
    @(posedge clock) wp_dir <= 32'hFFFF_FFFF;
    do_en <= 1'h1;
    do_src_sel <= 5'h11;
    do_xfer <= dio_pkg::DIO_XF_IRQ;
    for (int i = 1; i <= 9; i++) wr(32'hC000_0000 + 32'(i));
    @(posedge clock) do_wr_req <= 1'h0;
    @(negedge clock);
    `CHK(do_full, 1'h1)
    `CHK(do_count, 4'h8)
    `CHK(do_req, 1'h0)
    for (int i = 1; i <= 9; i++) begin
      pulse(1);
      `CHK(wp_out, 32'hC000_0000 + 32'(i > 8 ? 8 : i))
      `CHK(do_req, (8 - i) < 4)
    end
    `CHK(do_underrun, 1'h1)
    @(posedge clock) do_unf_clr <= 1'h1;
    do_xfer <= dio_pkg::DIO_XF_DMA;
    @(posedge clock) do_unf_clr <= 1'h0;
    @(negedge clock);
    `CHK(do_req, 1'h1)
    // regeneration repeats the loaded pair
    wr(32'h0000_00A1);
    wr(32'h0000_00A2);
    @(posedge clock) do_wr_req <= 1'h0;
    do_regen <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      pulse(1);
      `CHK(wp_out, (i % 2) ? 32'h0000_00A2 : 32'h0000_00A1)
    end
    `CHK(do_count, 4'h2)
    `CHK(do_underrun, 1'h0)
    `CHK(do_req, 1'h0)
    // function line modes, filter and timing input
    @(posedge clock) fl_filt[0] <= dio_pkg::DIO_FLT_LONG;
    fl_mode[1] <= dio_pkg::DIO_FL_SOUT;
    fl_static_out[1] <= 1'h1;
    fl_mode[2] <= dio_pkg::DIO_FL_TOUT;
    fl_tsel[2] <= 2'h2;
    timing_src <= 2'h1;
    fl_mode[3] <= dio_pkg::DIO_FL_TIN;
    di_src_sel <= 5'h03;
    di_xfer <= dio_pkg::DIO_XF_PIO;
    ext_fl[0] <= 1'h1;
    tick(10);
    ext_fl[0] <= 1'h0;
    tick(10);
    @(negedge clock);
    `CHK(fl_rd[0], 1'h0)
    `CHK(fl_oe[1], 1'h1)
    `CHK(fl_oe[0], 1'h0)
    `CHK(fl_out[1], 1'h1)
    `CHK(fl_out[2], 1'h1)
    @(posedge clock) ext_fl[0] <= 1'h1;
    ext_fl[3] <= 1'h1;
    tick(2);
    ext_fl[3] <= 1'h0;
    tick(28);
    @(negedge clock);
    `CHK(fl_rd[0], 1'h1)
    `CHK(di_count, 4'h1)
    tally_and_finish;
  end
endmodule : tb_dio_wave_port

// File: hw/dio_cfg.svh
// Purpose: constants for the digital waveform I/O port
// Assumes: 25 MHz system clock
// Notes:   times are in ns; counts derive from them
`ifndef DIO_CFG_SVH
`define DIO_CFG_SVH

`define DIO_CLK_NS       40
`define DIO_WP_W         32
`define DIO_FL_N         16
`define DIO_INT_N        8
`define DIO_FIFO_DEPTH   2047
`define DIO_STROBE_MAX_HZ 10000000

`define DIO_FLT_T0_NS    125
`define DIO_FLT_T1_NS    6425
`define DIO_FLT_T2_NS    2560000
// filter times are least times, so round up
`define DIO_FLT_C0 ((`DIO_FLT_T0_NS + `DIO_CLK_NS - 1) / `DIO_CLK_NS)
`define DIO_FLT_C1 ((`DIO_FLT_T1_NS + `DIO_CLK_NS - 1) / `DIO_CLK_NS)
`define DIO_FLT_C2 ((`DIO_FLT_T2_NS + `DIO_CLK_NS - 1) / `DIO_CLK_NS)

`endif

// File: hw/dio_debounce.sv
// Purpose: per-line glitch filter for both edges
// Assumes: input already synchronised to clock
// Notes:   a level must hold for the whole setting before it passes
`timescale 1ns/1ps
`include "dio_cfg.svh"

module dio_debounce #(
  parameter logic [15:0] C0 = 16'(`DIO_FLT_C0),
  parameter logic [15:0] C1 = 16'(`DIO_FLT_C1),
  parameter logic [15:0] C2 = 16'(`DIO_FLT_C2)
) (
  // clock and reset
  input  logic              clock,
  input  logic              reset,
  // line
  input  logic              din,
  input  dio_pkg::dio_filt_t sel,
  output logic              dout
);

  typedef struct packed {
    logic        lvl;
    logic [15:0] cnt;
  } dio_db_st_t;

  dio_db_st_t  q;
  dio_db_st_t  d;
  logic [15:0] lim;

  always_comb begin
    d = q;
    unique case (sel)
      dio_pkg::DIO_FLT_SHORT: lim = C0;
      dio_pkg::DIO_FLT_MID:   lim = C1;
      dio_pkg::DIO_FLT_LONG:  lim = C2;
      dio_pkg::DIO_FLT_OFF:   lim = 16'h0001;
    endcase
    // bypass follows the input with no hold time
    if (sel == dio_pkg::DIO_FLT_OFF || din == q.lvl) begin // RQ11
      d.lvl = din;
      d.cnt = 16'h0000;
    end else if (q.cnt + 16'h0001 >= lim) begin // RQ11
      d.lvl = din;
      d.cnt = 16'h0000;
    end else begin
      d.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.lvl;

endmodule : dio_debounce

// File: hw/dio_fifo.sv
// Purpose: sample queue in flip-flops, with optional recirculation
// Assumes: one clock, synchronous reset
// Notes:   a recirculating pop writes the head back to the tail
`timescale 1ns/1ps
`include "dio_cfg.svh"

module dio_fifo #(
  parameter int W     = `DIO_WP_W,
  parameter int DEPTH = `DIO_FIFO_DEPTH,
  localparam int AW   = $clog2(DEPTH),
  localparam int CW   = $clog2(DEPTH + 1)
) (
  // clock and reset
  input  logic          clock,
  input  logic          reset,
  // fill side
  input  logic          push,
  input  logic [W-1:0]  push_data,
  // drain side
  input  logic          pop,
  input  logic          recirc,
  output logic [W-1:0]  pop_data,
  // status
  output logic          full,
  output logic          empty,
  output logic [CW-1:0] count
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [CW-1:0]           cnt;
    logic                    full;
    logic                    empty;
  } dio_fifo_st_t;

  dio_fifo_st_t q;
  dio_fifo_st_t d;
  logic         do_pop;
  logic         do_push;

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    nxt = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : nxt

  always_comb begin
    d       = q;
    do_pop  = pop && !q.empty;
    // a push into a full queue only fits when a plain pop frees a slot
    do_push = push && !(do_pop && recirc) && (!q.full || do_pop);
    if (do_pop && recirc) begin
      d.mem[q.wr] = q.mem[q.rd];
      d.wr        = nxt(q.wr);
    end
    if (do_push) begin
      d.mem[q.wr] = push_data;
      d.wr        = nxt(q.wr);
    end
    if (do_pop) begin
      d.rd = nxt(q.rd);
    end
    d.cnt   = q.cnt + CW'(do_push) - CW'(do_pop && !recirc);
    d.full  = (d.cnt == CW'(DEPTH));
    d.empty = (d.cnt == '0);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      q       <= '0;
      q.empty <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign pop_data = q.mem[q.rd];
  assign full     = q.full;
  assign empty    = q.empty;
  assign count    = q.cnt;

endmodule : dio_fifo

// File: hw/dio_pkg.sv
// Purpose: shared types of the digital waveform I/O port
// Assumes: nothing beyond the config header
// Notes:   encodings follow declaration order
package dio_pkg;

  typedef enum logic [1:0] {
    DIO_FL_SIN,
    DIO_FL_SOUT,
    DIO_FL_TIN,
    DIO_FL_TOUT
  } dio_flmode_t;

  typedef enum logic [1:0] {
    DIO_FLT_OFF,
    DIO_FLT_SHORT,
    DIO_FLT_MID,
    DIO_FLT_LONG
  } dio_filt_t;

  typedef enum logic [1:0] {
    DIO_XF_PIO,
    DIO_XF_IRQ,
    DIO_XF_DMA,
    DIO_XF_RSV
  } dio_xfer_t;

endpackage : dio_pkg

// File: hw/dio_wave_port.sv
// Purpose: wide waveform port with capture and generation queues, plus function lines
// Assumes: strobes arrive from function lines or internal sources; 25 MHz clock
// Notes:   no timing engine here; strobes are edge detected, so at most 10 MHz
`timescale 1ns/1ps
`include "dio_cfg.svh"

// Contract
// RQ1: software sets each terminal's direction as input or output on its own.
// RQ2: only the wide port carries clocked waveforms, full 32 bits per sample.
// RQ3: output samples wait in a 2,047-entry generation queue before driving.
// RQ4: captured samples wait in a 2,047-entry acquisition queue until drained.
// RQ5: capture strobe accepted from zero up to 10 MHz.
// RQ6: generation repeats the queue or streams fresh samples, up to 10 MHz.
// RQ7: strobes come from another subsystem or a pin, never generated here.
// RQ8: strobe source selectable from function lines or internal strobes.
// RQ9: host moves data by DMA request, interrupt request or programmed access.
// RQ10: function line acts as static in, static out, timing in or timing out.
// RQ11: each function input has a debounce filter: three times or bypass.
// RQ12: flag capture overflow and streaming underrun so software sees lost samples.
module dio_wave_port #(
  parameter int          W     = `DIO_WP_W,
  parameter int          FL_N  = `DIO_FL_N,
  parameter int          INT_N = `DIO_INT_N,
  parameter int          DEPTH = `DIO_FIFO_DEPTH,
  parameter logic [15:0] FLT_C2 = 16'(`DIO_FLT_C2),
  localparam int         CW    = $clog2(DEPTH + 1)
) (
  // clock and reset
  input  logic                              clock,
  input  logic                              reset,
  // wide port pins
  input  logic [W-1:0]                      wp_in,
  output logic [W-1:0]                      wp_out,
  output logic [W-1:0]                      wp_oe,
  // wide port static control
  input  logic [W-1:0]                      wp_dir,
  input  logic [W-1:0]                      wp_static_out,
  output logic [W-1:0]                      wp_rd,
  // function line pins
  input  logic [FL_N-1:0]                   fl_in,
  output logic [FL_N-1:0]                   fl_out,
  output logic [FL_N-1:0]                   fl_oe,
  // function line control
  input  dio_pkg::dio_flmode_t [FL_N-1:0]   fl_mode,
  input  dio_pkg::dio_filt_t [FL_N-1:0]     fl_filt,
  input  logic [FL_N-1:0][1:0]              fl_tsel,
  input  logic [FL_N-1:0]                   fl_static_out,
  output logic [FL_N-1:0]                   fl_rd,
  // internal strobe and timing sources
  input  logic [INT_N-1:0]                  int_strobe,
  input  logic [1:0]                        timing_src,
  // capture control and host drain
  input  logic                              di_en,
  input  logic [4:0]                        di_src_sel,
  input  dio_pkg::dio_xfer_t                di_xfer,
  input  logic                              di_rd_req,
  output logic [W-1:0]                      di_rd_data,
  output logic                              di_rd_ack,
  output logic                              di_req,
  output logic [CW-1:0]                     di_count,
  output logic                              di_overflow,
  input  logic                              di_ovf_clr,
  // generation control and host fill
  input  logic                              do_en,
  input  logic                              do_regen,
  input  logic [4:0]                        do_src_sel,
  input  dio_pkg::dio_xfer_t                do_xfer,
  input  logic                              do_wr_req,
  input  logic [W-1:0]                      do_wr_data,
  output logic                              do_full,
  output logic                              do_req,
  output logic [CW-1:0]                     do_count,
  output logic                              do_underrun,
  input  logic                              do_unf_clr
);

  localparam logic [CW-1:0] HALF = CW'(DEPTH / 2);

  typedef struct packed {
    logic [W-1:0]    wp_s1;
    logic [W-1:0]    wp_s2;
    logic [FL_N-1:0] fl_s1;
    logic [FL_N-1:0] fl_s2;
    logic            di_prev;
    logic            do_prev;
    logic [W-1:0]    wp_out;
    logic [W-1:0]    wp_oe;
    logic [W-1:0]    wp_rd;
    logic [FL_N-1:0] fl_out;
    logic [FL_N-1:0] fl_oe;
    logic [FL_N-1:0] fl_rd;
    logic [W-1:0]    di_data;
    logic            di_ack;
    logic            di_ovf;
    logic            do_unf;
    logic            di_req;
    logic            do_req;
  } dio_top_st_t;

  dio_top_st_t     q;
  dio_top_st_t     d;
  logic [FL_N-1:0] fl_clean;
  logic [FL_N-1:0] fl_tin;
  logic [FL_N-1:0] fl_out_d;
  logic [FL_N-1:0] fl_oe_d;
  logic [31:0]     src;
  logic            di_lvl;
  logic            do_lvl;
  logic            di_edge;
  logic            do_edge;
  logic            di_push;
  logic            di_pop;
  logic            do_push;
  logic            do_pop;
  logic [W-1:0]    di_head;
  logic [W-1:0]    do_head;
  logic            di_full;
  logic            di_empty;
  logic            do_empty;
  logic [CW-1:0]   di_cnt;
  logic [CW-1:0]   do_cnt;

  // strobe sources: timing-input function lines, then internal strobes
  assign src    = 32'({int_strobe, fl_tin}); // RQ8
  assign di_lvl = src[di_src_sel]; // RQ8 RQ7
  assign do_lvl = src[do_src_sel]; // RQ8 RQ7
  // edge detection needs two clocks per strobe period, which 10 MHz gives
  assign di_edge = di_lvl && !q.di_prev; // RQ5
  assign do_edge = do_lvl && !q.do_prev; // RQ6

  genvar i;
  generate
    for (i = 0; i < FL_N; i++) begin : g_fl
      logic [3:0] tout;
      logic       out_b;
      logic       oe_b;
      dio_debounce #(
        .C0   (16'(`DIO_FLT_C0)),
        .C1   (16'(`DIO_FLT_C1)),
        .C2   (FLT_C2)
      ) u_db (
        .clock (clock),
        .reset (reset),
        .din   (q.fl_s2[i]),
        .sel   (fl_filt[i]),
        .dout  (fl_clean[i])
      );
      // waveform strobes, acquisition timing and counter timing can leave on a line
      assign tout        = {timing_src, do_lvl, di_lvl};
      assign fl_tin[i]   = fl_clean[i] && (fl_mode[i] == dio_pkg::DIO_FL_TIN); // RQ10
      // only the two output modes drive, so an input line is never fought over
      always_comb begin
        out_b = 1'b0;
        oe_b  = 1'b0;
        unique case (fl_mode[i])
          dio_pkg::DIO_FL_SIN: begin
            out_b = 1'b0;
            oe_b  = 1'b0;
          end
          dio_pkg::DIO_FL_SOUT: begin
            out_b = fl_static_out[i]; // RQ10
            oe_b  = 1'b1; // RQ1 RQ10
          end
          dio_pkg::DIO_FL_TIN: begin
            out_b = 1'b0;
            oe_b  = 1'b0;
          end
          dio_pkg::DIO_FL_TOUT: begin
            out_b = tout[fl_tsel[i]]; // RQ10
            oe_b  = 1'b1; // RQ1 RQ10
          end
        endcase
      end
      assign fl_out_d[i] = out_b;
      assign fl_oe_d[i]  = oe_b;
    end
  endgenerate

  // acquisition queue
  dio_fifo #(
    .W      (W),
    .DEPTH  (DEPTH)
  ) u_acq (
    .clock     (clock),
    .reset     (reset),
    .push      (di_push),
    .push_data (q.wp_s2),
    .pop       (di_pop),
    .recirc    (1'b0),
    .pop_data  (di_head),
    .full      (di_full),
    .empty     (di_empty),
    .count     (di_cnt)
  ); // RQ4

  // generation queue
  dio_fifo #(
    .W      (W),
    .DEPTH  (DEPTH)
  ) u_gen (
    .clock     (clock),
    .reset     (reset),
    .push      (do_push),
    .push_data (do_wr_data),
    .pop       (do_pop),
    .recirc    (do_regen),
    .pop_data  (do_head),
    .full      (do_full),
    .empty     (do_empty),
    .count     (do_cnt)
  ); // RQ3

  // a full queue cannot take the sample unless the host drains in the same cycle
  assign di_push = di_en && di_edge; // RQ2 RQ5
  assign di_pop  = di_rd_req && !di_empty; // RQ9
  // host writes are ignored while repeating so the loop content stays fixed
  assign do_push = do_wr_req && !do_regen; // RQ6
  assign do_pop  = do_en && do_edge; // RQ6

  always_comb begin
    d = q;
    d.wp_s1   = wp_in;
    d.wp_s2   = q.wp_s1;
    d.fl_s1   = fl_in;
    d.fl_s2   = q.fl_s1;
    d.di_prev = di_lvl;
    d.do_prev = do_lvl;
    d.wp_oe   = wp_dir; // RQ1
    d.wp_rd   = q.wp_s2;
    d.fl_rd   = fl_clean;
    d.fl_out  = fl_out_d;
    d.fl_oe   = fl_oe_d;

    // static drive when not generating, queue head on each update strobe
    if (!do_en) begin
      d.wp_out = wp_static_out; // RQ1
    end else if (do_pop && !do_empty) begin
      d.wp_out = do_head; // RQ2 RQ3 RQ6
    end else begin
      // an update on an empty queue leaves the last sample standing on the pins
      d.wp_out = q.wp_out;
    end

    d.di_ack = di_pop; // RQ9
    if (di_pop) begin
      d.di_data = di_head; // RQ9
    end

    // set wins over clear so an event in the clearing cycle is kept
    if (di_ovf_clr) begin
      d.di_ovf = 1'b0;
    end
    if (di_push && di_full && !di_pop) begin
      d.di_ovf = 1'b1; // RQ12
    end
    if (do_unf_clr) begin
      d.do_unf = 1'b0;
    end
    if (do_pop && do_empty) begin
      d.do_unf = 1'b1; // RQ12
    end

    // requests lag the count by one cycle; programmed access polls the counts instead
    unique case (di_xfer)
      dio_pkg::DIO_XF_DMA: d.di_req = !di_empty; // RQ9
      dio_pkg::DIO_XF_IRQ: d.di_req = (di_cnt >= HALF); // RQ9
      dio_pkg::DIO_XF_PIO: d.di_req = 1'b0;
      dio_pkg::DIO_XF_RSV: d.di_req = 1'b0;
    endcase
    unique case (do_xfer)
      dio_pkg::DIO_XF_DMA: d.do_req = !do_full && !do_regen; // RQ9
      dio_pkg::DIO_XF_IRQ: d.do_req = (do_cnt < HALF) && !do_regen; // RQ9
      dio_pkg::DIO_XF_PIO: d.do_req = 1'b0;
      dio_pkg::DIO_XF_RSV: d.do_req = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // pin side
  assign wp_out      = q.wp_out;
  assign wp_oe       = q.wp_oe;
  assign wp_rd       = q.wp_rd;
  assign fl_out      = q.fl_out;
  assign fl_oe       = q.fl_oe;
  assign fl_rd       = q.fl_rd;
  // host side
  assign di_rd_data  = q.di_data;
  assign di_rd_ack   = q.di_ack;
  assign di_req      = q.di_req;
  assign di_count    = di_cnt;
  assign di_overflow = q.di_ovf;
  assign do_req      = q.do_req;
  assign do_count    = do_cnt;
  assign do_underrun = q.do_unf;

endmodule : dio_wave_port
